// [pkg/iesel_pkg.sv]
package iesel_pkg;

    // Counts
    localparam int IESEL_NUM_CPU_INT = 16;
    localparam int IESEL_FIRST_MASKABLE = 4;
    localparam int IESEL_NUM_SEL = 12;
    localparam int IESEL_FIELDS_PER_REG = 6;
    localparam int IESEL_CODE_W = 5;
    localparam int IESEL_NUM_CODES = 32;
    localparam int IESEL_NUM_CHAN = 64;

    // Register byte addresses
    localparam logic [31:0] IESEL_ADDR_SEL_HI = 32'h019c_0000;
    localparam logic [31:0] IESEL_ADDR_SEL_LO = 32'h019c_0004;
    localparam logic [31:0] IESEL_ADDR_EN_LO = 32'h019c_0008;
    localparam logic [31:0] IESEL_ADDR_EN_HI = 32'h019c_000c;
    localparam logic [31:0] IESEL_ADDR_CAP_LO = 32'h019c_0010;
    localparam logic [31:0] IESEL_ADDR_CAP_HI = 32'h019c_0014;

    // Selector field positions, ascending input order
    localparam int IESEL_FIELD_LSB [6] = '{0, 5, 10, 16, 21, 26};
    localparam logic [31:0] IESEL_RSV_MASK = 32'h8000_8000;

    // Selector reset codes, entry 0 is input 4
    localparam logic [11:0][4:0] IESEL_SEL_RST = {
        5'h02, 5'h01, 5'h00, 5'h0b, 5'h0a, 5'h03,
        5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04
    };

    // Source codes; codes 5-7, 13-15 and 18 are reached through ranges, other missing codes are reserved and select nothing
    typedef enum logic [4:0] {
        IESEL_C_HOST = 5'h00,
        IESEL_C_TMR0 = 5'h01,
        IESEL_C_TMR1 = 5'h02,
        IESEL_C_SDRA = 5'h03,
        IESEL_C_GPIO4 = 5'h04,
        IESEL_C_DMA_DONE = 5'h08,
        IESEL_C_EMU_XFER = 5'h09,
        IESEL_C_EMU_RX = 5'h0a,
        IESEL_C_EMU_TX = 5'h0b,
        IESEL_C_SER0_TX = 5'h0c,
        IESEL_C_GPIO0 = 5'h10,
        IESEL_C_SER2_TX = 5'h11,
        IESEL_C_SER2_RX = 5'h12,
        IESEL_C_TMR2 = 5'h13,
        IESEL_C_SDRB = 5'h14,
        IESEL_C_CELL = 5'h17,
        IESEL_C_VIT = 5'h1e,
        IESEL_C_TURBO = 5'h1f
    } iesel_code_t;

    typedef struct packed {
        logic host;
        logic [2:0] tmr;
        logic sdr_a;
        logic sdr_b;
        logic [15:0] gpio;
        logic dma_done;
        logic emu_xfer;
        logic emu_rx;
        logic emu_tx;
        logic [1:0] ser0_irq;
        logic [1:0] ser1_irq;
        logic [1:0] ser2_irq;
        logic cell_irq;
        logic vit_irq;
        logic turbo_irq;
        logic [1:0] ser0_dma;
        logic [1:0] ser1_dma;
        logic [1:0] ser2_dma;
        logic [1:0] vit_dma;
        logic [1:0] turbo_dma;
        logic [1:0] cell_dma;
        logic [63:0] xfer_done;
        logic [63:0] alt_xfer_done;
    } iesel_periph_t;

    typedef struct packed {
        logic [11:0][4:0] sel;
        logic [63:0] en;
        logic [63:0] cap;
        logic [15:0] cpu_int;
        logic [63:0] dma_evt;
        logic [63:0] dma_req;
        logic wreq;
        logic [31:0] rdata;
    } iesel_state_t;

    localparam iesel_state_t IESEL_STATE_RST = '{
        sel: IESEL_SEL_RST,
        wreq: 1'b1,
        default: '0
    };

endpackage

// [pkg/iesel_map_if.sv]
`timescale 1ns/1ns
interface iesel_map_if;
    iesel_pkg::iesel_periph_t periph;
    logic [31:0] code_src;
    logic [63:0] chan_evt;

    modport mapper (input periph, output code_src, output chan_evt);
    modport user (output periph, input code_src, input chan_evt);
endinterface

// [design/iesel_event_map.sv]
`timescale 1ns/1ns
module iesel_event_map (
    iesel_map_if.mapper m
);
    import iesel_pkg::*;

    // Selector code table; reserved codes stay low
    always_comb begin
        m.code_src = '0;
        m.code_src[IESEL_C_HOST] = m.periph.host;
        m.code_src[IESEL_C_TMR0] = m.periph.tmr[0];
        m.code_src[IESEL_C_TMR1] = m.periph.tmr[1];
        m.code_src[IESEL_C_SDRA] = m.periph.sdr_a;
        m.code_src[IESEL_C_GPIO4 +: 4] = m.periph.gpio[7:4];
        m.code_src[IESEL_C_DMA_DONE] = m.periph.dma_done;
        m.code_src[IESEL_C_EMU_XFER] = m.periph.emu_xfer;
        m.code_src[IESEL_C_EMU_RX] = m.periph.emu_rx;
        m.code_src[IESEL_C_EMU_TX] = m.periph.emu_tx;
        m.code_src[IESEL_C_SER0_TX +: 4] = {m.periph.ser1_irq, m.periph.ser0_irq};
        m.code_src[IESEL_C_GPIO0] = m.periph.gpio[0];
        m.code_src[IESEL_C_SER2_TX +: 2] = m.periph.ser2_irq;
        m.code_src[IESEL_C_TMR2] = m.periph.tmr[2];
        m.code_src[IESEL_C_SDRB] = m.periph.sdr_b;
        m.code_src[IESEL_C_CELL] = m.periph.cell_irq;
        m.code_src[IESEL_C_VIT] = m.periph.vit_irq;
        m.code_src[IESEL_C_TURBO] = m.periph.turbo_irq;
    end

    // Fixed channel table, no software remap
    always_comb begin
        m.chan_evt = '0;
        m.chan_evt[0] = m.periph.host;
        m.chan_evt[3:1] = {m.periph.sdr_a, m.periph.tmr[1:0]};
        m.chan_evt[7:4] = m.periph.gpio[7:4];
        m.chan_evt[11:8] = m.periph.gpio[3:0];
        m.chan_evt[15:12] = {m.periph.ser1_dma, m.periph.ser0_dma};
        m.chan_evt[18:17] = m.periph.ser2_dma;
        m.chan_evt[20:19] = {m.periph.sdr_b, m.periph.tmr[2]};
        m.chan_evt[31:28] = {m.periph.turbo_dma, m.periph.vit_dma};
        m.chan_evt[32] = m.periph.cell_dma[0];
        m.chan_evt[40] = m.periph.cell_dma[1];
        m.chan_evt[55:48] = m.periph.gpio[15:8];
        // Chaining completions reach every channel
        m.chan_evt = m.chan_evt | m.periph.xfer_done | m.periph.alt_xfer_done;
    end

endmodule

// [design/iesel_top.sv]
// Function
// - Sixteen core inputs; input 0 is reset, highest priority, 15 lowest.
// - Inputs 0 to 3 fixed and unmaskable; 1 is NMI, 2 and 3 unused.
// - Inputs 4 to 15 take default sources at reset, software may reassign.
// - Each maskable source is a 5-bit code in the high or low selector.
// - Low register feeds inputs 4-9, high feeds 10-15, six fields each.
// - Codes 4 to 7 pick GPIO/pin events 4 to 7, defaults for 4-7.
// - Code 8 picks DMA completion (input 8), code 9 emulation transfer (9).
// - Codes 10 and 11 pick emulation receive and transmit, inputs 11, 12.
// - Defaults: input 10 refresh A, 13 host, 14 timer 0, 15 timer 1.
// - Codes 12-20 pick serial ports, GPIO 0, timer 2, refresh B.
// - Codes 23, 30, 31 pick cell, Viterbi, turbo; any maskable input.
// - Each of 64 DMA channels has at most one fixed event, not remappable.
// - Channel events are captured even while disabled.
// - Channels 0-3, 19, 20 take host, timers and refresh timers.
// - Channels 4-11 and 48-55 take GPIO events.
// - Channels 12-15, 17, 18, 28-32, 40 take serial, coprocessor, cell.
// - Every channel also syncs on completion or alternate completion.
// - Channels 16, 21-27, 33-39, 41-47, 56-63 have no peripheral event.
`timescale 1ns/1ns
module iesel_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Avalon-MM slave
    input wire logic [31:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Fixed core sources
    input wire logic core_reset_i,
    input wire logic nmi_i,
    // Peripheral interrupt sources
    input wire logic host_to_core_event_i,
    input wire logic timer_zero_event_i,
    input wire logic timer_one_event_i,
    input wire logic timer_two_event_i,
    input wire logic sdram_refresh_a_event_i,
    input wire logic sdram_refresh_b_event_i,
    input wire logic [15:0] gpio_event_i,
    input wire logic dma_completion_event_i,
    input wire logic emulation_transfer_event_i,
    input wire logic emulation_rx_event_i,
    input wire logic emulation_tx_event_i,
    input wire logic serial0_tx_irq_i,
    input wire logic serial0_rx_irq_i,
    input wire logic serial1_tx_irq_i,
    input wire logic serial1_rx_irq_i,
    input wire logic serial2_tx_irq_i,
    input wire logic serial2_rx_irq_i,
    input wire logic cell_interface_irq_i,
    input wire logic viterbi_coproc_irq_i,
    input wire logic turbo_coproc_irq_i,
    // Peripheral DMA events
    input wire logic serial0_tx_dma_event_i,
    input wire logic serial0_rx_dma_event_i,
    input wire logic serial1_tx_dma_event_i,
    input wire logic serial1_rx_dma_event_i,
    input wire logic serial2_tx_dma_event_i,
    input wire logic serial2_rx_dma_event_i,
    input wire logic viterbi_rx_dma_event_i,
    input wire logic viterbi_tx_dma_event_i,
    input wire logic turbo_rx_dma_event_i,
    input wire logic turbo_tx_dma_event_i,
    input wire logic cell_rx_dma_event_i,
    input wire logic cell_tx_dma_event_i,
    input wire logic [63:0] xfer_done_i,
    input wire logic [63:0] alt_xfer_done_i,
    // Core and DMA side
    output logic [15:0] cpu_int_o,
    output logic [63:0] dma_event_o,
    output logic [63:0] dma_request_o
);
    import iesel_pkg::*;

    iesel_state_t st_q;
    iesel_state_t st_d;
    logic req;
    logic accept;
    logic [31:0] be_mask;
    logic [31:0] wr_merge;
    logic [63:0] cap_clr;

    iesel_map_if m_if ();

    assign m_if.periph = '{
        host: host_to_core_event_i,
        tmr: {timer_two_event_i, timer_one_event_i, timer_zero_event_i},
        sdr_a: sdram_refresh_a_event_i,
        sdr_b: sdram_refresh_b_event_i,
        gpio: gpio_event_i,
        dma_done: dma_completion_event_i,
        emu_xfer: emulation_transfer_event_i,
        emu_rx: emulation_rx_event_i,
        emu_tx: emulation_tx_event_i,
        ser0_irq: {serial0_rx_irq_i, serial0_tx_irq_i},
        ser1_irq: {serial1_rx_irq_i, serial1_tx_irq_i},
        ser2_irq: {serial2_rx_irq_i, serial2_tx_irq_i},
        cell_irq: cell_interface_irq_i,
        vit_irq: viterbi_coproc_irq_i,
        turbo_irq: turbo_coproc_irq_i,
        ser0_dma: {serial0_rx_dma_event_i, serial0_tx_dma_event_i},
        ser1_dma: {serial1_rx_dma_event_i, serial1_tx_dma_event_i},
        ser2_dma: {serial2_rx_dma_event_i, serial2_tx_dma_event_i},
        vit_dma: {viterbi_tx_dma_event_i, viterbi_rx_dma_event_i},
        turbo_dma: {turbo_tx_dma_event_i, turbo_rx_dma_event_i},
        cell_dma: {cell_tx_dma_event_i, cell_rx_dma_event_i},
        xfer_done: xfer_done_i,
        alt_xfer_done: alt_xfer_done_i
    };

    iesel_event_map u_map (
        .m (m_if.mapper)
    );

    // Reserved bits fall out of the packing and so read as zero
    function automatic logic [31:0] sel_pack(input logic [5:0][4:0] f);
        logic [31:0] r;
        r = '0;
        for (int k = 0; k < IESEL_FIELDS_PER_REG; k++) begin
            r[IESEL_FIELD_LSB[k] +: IESEL_CODE_W] = f[k];
        end
        return r;
    endfunction

    function automatic logic [5:0][4:0] sel_unpack(input logic [31:0] r);
        logic [5:0][4:0] f;
        f = '0;
        for (int k = 0; k < IESEL_FIELDS_PER_REG; k++) begin
            f[k] = r[IESEL_FIELD_LSB[k] +: IESEL_CODE_W];
        end
        return f;
    endfunction

    function automatic logic [31:0] reg_read(input iesel_state_t s, input logic [31:0] a);
        logic [31:0] r;
        r = '0;
        unique case (a)
            IESEL_ADDR_SEL_HI: r = sel_pack(s.sel[11:6]);
            IESEL_ADDR_SEL_LO: r = sel_pack(s.sel[5:0]);
            IESEL_ADDR_EN_LO: r = s.en[31:0];
            IESEL_ADDR_EN_HI: r = s.en[63:32];
            IESEL_ADDR_CAP_LO: r = s.cap[31:0];
            IESEL_ADDR_CAP_HI: r = s.cap[63:32];
            default: r = '0;
        endcase
        return r;
    endfunction

    always_comb begin
        st_d = st_q;
        req = avs_read_i || avs_write_i;
        // One wait cycle per access so that read data come from a flop
        accept = req && !st_q.wreq;
        st_d.wreq = !(req && st_q.wreq);
        st_d.rdata = reg_read(st_q, avs_address_i);
        be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        wr_merge = (reg_read(st_q, avs_address_i) & ~be_mask)
                   | (avs_writedata_i & be_mask);
        cap_clr = '0;
        if (accept && avs_write_i) begin
            unique case (avs_address_i)
                IESEL_ADDR_SEL_HI: st_d.sel[11:6] = sel_unpack(wr_merge);
                IESEL_ADDR_SEL_LO: st_d.sel[5:0] = sel_unpack(wr_merge);
                IESEL_ADDR_EN_LO: st_d.en[31:0] = wr_merge;
                IESEL_ADDR_EN_HI: st_d.en[63:32] = wr_merge;
                IESEL_ADDR_CAP_LO: cap_clr[31:0] = avs_writedata_i & be_mask;
                IESEL_ADDR_CAP_HI: cap_clr[63:32] = avs_writedata_i & be_mask;
                default: cap_clr = '0;
            endcase
        end
        // Capture ignores enable; a new event beats a same-cycle clear
        st_d.cap = (st_q.cap & ~cap_clr) | m_if.chan_evt;
        st_d.dma_evt = m_if.chan_evt;
        st_d.dma_req = st_q.cap & st_q.en;
        // Priority itself is resolved in the core; input order is the priority
        st_d.cpu_int[0] = core_reset_i;
        st_d.cpu_int[1] = nmi_i;
        st_d.cpu_int[3:2] = 2'b00;
        for (int i = 0; i < IESEL_NUM_SEL; i++) begin
            // Reserved codes map to a constant low source
            st_d.cpu_int[IESEL_FIRST_MASKABLE + i] = m_if.code_src[st_q.sel[i]];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q <= IESEL_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign avs_readdata_o = st_q.rdata;
    assign avs_waitrequest_o = st_q.wreq;
    assign cpu_int_o = st_q.cpu_int;
    assign dma_event_o = st_q.dma_evt;
    assign dma_request_o = st_q.dma_req;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    property p_fixed_inputs;
        !$past(srst_i) |-> cpu_int_o[1:0] == {$past(nmi_i), $past(core_reset_i)}
            && cpu_int_o[3:2] == 2'b00;
    endproperty
    a_fixed_inputs: assert property (p_fixed_inputs)
        else $error("fixed core inputs wrong");

    property p_reset_defaults;
        $past(srst_i) |-> st_q.sel == IESEL_SEL_RST;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("selector defaults wrong after reset");

    property p_read_high;
        avs_read_i && !avs_waitrequest_o && avs_address_i == IESEL_ADDR_SEL_HI
            |-> avs_readdata_o == sel_pack(st_q.sel[11:6])
            && (avs_readdata_o & IESEL_RSV_MASK) == 32'h0000_0000;
    endproperty
    a_read_high: assert property (p_read_high)
        else $error("high selector readback wrong");

    property p_write_low;
        avs_write_i && !avs_waitrequest_o && avs_address_i == IESEL_ADDR_SEL_LO
            && avs_byteenable_i == 4'hf
            |=> st_q.sel[0] == $past(avs_writedata_i[4:0])
            && st_q.sel[3] == $past(avs_writedata_i[20:16])
            && st_q.sel[5] == $past(avs_writedata_i[30:26]);
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("low selector write not applied");

    property p_route_first;
        !$past(srst_i) && $past(st_q.sel[0]) == IESEL_C_GPIO4
            |-> cpu_int_o[4] == $past(gpio_event_i[4]);
    endproperty
    a_route_first: assert property (p_route_first)
        else $error("input 4 not following its code");

    property p_route_last;
        !$past(srst_i) && $past(st_q.sel[11]) == IESEL_C_TURBO
            |-> cpu_int_o[15] == $past(turbo_coproc_irq_i);
    endproperty
    a_route_last: assert property (p_route_last)
        else $error("input 15 not following turbo source");

    property p_chan_fixed;
        !$past(srst_i) && !$past(xfer_done_i[19]) && !$past(alt_xfer_done_i[19])
            |-> dma_event_o[19] == $past(timer_two_event_i)
            && dma_event_o[0] == $past(host_to_core_event_i
            | xfer_done_i[0] | alt_xfer_done_i[0]);
    endproperty
    a_chan_fixed: assert property (p_chan_fixed)
        else $error("fixed channel event wrong");

    property p_chan_gpio;
        !$past(srst_i) && !$past(xfer_done_i[48] | alt_xfer_done_i[48])
            |-> dma_event_o[48] == $past(gpio_event_i[8]);
    endproperty
    a_chan_gpio: assert property (p_chan_gpio)
        else $error("gpio channel event wrong");

    property p_chan_empty;
        !$past(srst_i) |-> dma_event_o[21] == $past(xfer_done_i[21] | alt_xfer_done_i[21]);
    endproperty
    a_chan_empty: assert property (p_chan_empty)
        else $error("empty channel shows a peripheral event");

    property p_chain;
        alt_xfer_done_i[63] |=> dma_event_o[63];
    endproperty
    a_chain: assert property (p_chain)
        else $error("completion did not trigger channel");

    property p_capture_disabled;
        m_if.chan_evt[5] && !st_q.en[5] |=> st_q.cap[5] ##1 1'b1;
    endproperty
    a_capture_disabled: assert property (p_capture_disabled)
        else $error("disabled event not captured");

    property p_wait_bound;
        req && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("waitrequest held longer than one cycle");

    c_read_high: cover property (avs_read_i && !avs_waitrequest_o
        && avs_address_i == IESEL_ADDR_SEL_HI);
    c_write_low: cover property (avs_write_i && !avs_waitrequest_o
        && avs_address_i == IESEL_ADDR_SEL_LO);
    c_int_fire: cover property ($rose(cpu_int_o[4]));
    c_dma_req: cover property ($rose(dma_request_o[32]));

endmodule

// [verification/iesel_core_model.sv]
`timescale 1ns/1ns
module iesel_core_model (
    // Core side
    input wire logic [15:0] cpu_int_i,
    output logic [4:0] top_int_o
);
    // Lowest pending number is served first; 16 means nothing pending
    always_comb begin
        top_int_o = 5'h10;
        for (int n = 15; n >= 0; n--) begin
            if (cpu_int_i[n]) begin
                top_int_o = 5'(n);
            end
        end
    end
endmodule

// [verification/interrupt_event_selector_tb.sv]
`timescale 1ns/1ns
module interrupt_event_selector_tb;
    import iesel_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] be = 4'hf;
    logic [31:0] rdata;
    logic wait_req;
    logic core_rst = 1'b0;
    logic nmi = 1'b0;
    logic [63:0] stim = '0;
    logic [63:0] xd = '0;
    logic [63:0] axd = '0;
    logic [15:0] cpu_int;
    logic [63:0] dma_evt;
    logic [63:0] dma_req;
    logic [4:0] top_int;
    int errors = 0;
    int cmp_count = 0;
    int dflt [12] = '{4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};
    always #50 clk = ~clk;
    iesel_top i_dut (
        .clk_i(clk), .srst_i(srst), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
        .core_reset_i(core_rst), .nmi_i(nmi), .host_to_core_event_i(stim[0]),
        .timer_zero_event_i(stim[1]), .timer_one_event_i(stim[2]),
        .timer_two_event_i(stim[19]), .sdram_refresh_a_event_i(stim[3]),
        .sdram_refresh_b_event_i(stim[20]),
        .gpio_event_i({stim[42:35], stim[7:4], stim[34:32], stim[16]}),
        .dma_completion_event_i(stim[8]), .emulation_transfer_event_i(stim[9]),
        .emulation_rx_event_i(stim[10]), .emulation_tx_event_i(stim[11]),
        .serial0_tx_irq_i(stim[12]), .serial0_rx_irq_i(stim[13]),
        .serial1_tx_irq_i(stim[14]), .serial1_rx_irq_i(stim[15]),
        .serial2_tx_irq_i(stim[17]), .serial2_rx_irq_i(stim[18]),
        .cell_interface_irq_i(stim[23]), .viterbi_coproc_irq_i(stim[30]),
        .turbo_coproc_irq_i(stim[31]), .serial0_tx_dma_event_i(stim[43]),
        .serial0_rx_dma_event_i(stim[44]), .serial1_tx_dma_event_i(stim[45]),
        .serial1_rx_dma_event_i(stim[46]), .serial2_tx_dma_event_i(stim[47]),
        .serial2_rx_dma_event_i(stim[48]), .viterbi_rx_dma_event_i(stim[49]),
        .viterbi_tx_dma_event_i(stim[50]), .turbo_rx_dma_event_i(stim[51]),
        .turbo_tx_dma_event_i(stim[52]), .cell_rx_dma_event_i(stim[53]),
        .cell_tx_dma_event_i(stim[54]), .xfer_done_i(xd), .alt_xfer_done_i(axd),
        .cpu_int_o(cpu_int), .dma_event_o(dma_evt), .dma_request_o(dma_req)
    );
    iesel_core_model i_core (.cpu_int_i(cpu_int), .top_int_o(top_int));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until waitrequest is sampled low; no cycle count assumed
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] q);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= b;
        do begin
            @(posedge clk);
        end while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] q;
        bus(1'b1, a, d, b, q);
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, '0, 4'hf, q);
        check(what, q, exp);
    endtask
    task automatic nap();
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic put(input int i, input logic v);
        @(posedge clk);
        stim[i] <= v;
        nap();
    endtask
    function automatic int lsb(input int f);
        return f * 5 + ((f > 2) ? 1 : 0);
    endfunction
    function automatic logic [31:0] pack(input int b);
        logic [31:0] r;
        r = '0;
        for (int f = 0; f < 6; f++) begin
            r = r | (32'(dflt[b + f]) << lsb(f));
        end
        return r;
    endfunction
    // Index into stim of the fixed event of a channel, -1 where none is attached
    function automatic int ch_idx(input int ch);
        case (ch)
            0, 1, 2, 3, 4, 5, 6, 7, 19, 20: return ch;
            8: return 16;
            9, 10, 11: return ch + 23;
            12, 13, 14, 15: return ch + 31;
            17, 18: return ch + 30;
            28, 29, 30, 31: return ch + 21;
            32: return 53;
            40: return 54;
            default: return (ch >= 48 && ch <= 55) ? ch - 13 : -1;
        endcase
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        results();
    end
    initial begin
        int k;
        logic ok;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk("low selector reset", IESEL_ADDR_SEL_LO, pack(0));
        rd_chk("high selector reset", IESEL_ADDR_SEL_HI, pack(6));
        for (int i = 4; i < 16; i++) begin
            put(dflt[i - 4], 1'b1);
            check("default routing", cpu_int[15:4], 64'(12'h1 << (i - 4)));
            put(dflt[i - 4], 1'b0);
        end
        $display("reset defaults done");
        wr_reg(IESEL_ADDR_SEL_LO, 32'hffff_ffff, 4'hf);
        rd_chk("reserved bits", IESEL_ADDR_SEL_LO, 32'h7fff_7fff);
        wr_reg(IESEL_ADDR_SEL_LO, 32'h0, 4'h1);
        rd_chk("byte lane write", IESEL_ADDR_SEL_LO, 32'h7fff_7f00);
        rd_chk("unmapped read", 32'h019c_0020, 32'h0);
        $display("register access done");
        // Reserved codes are tried with every source raised
        for (int c = 0; c < 32; c++) begin
            int i;
            i = 4 + ((c + 4) % 12);
            ok = !(c == 21 || c == 22 || (c >= 24 && c <= 29));
            wr_reg((i < 10) ? IESEL_ADDR_SEL_LO : IESEL_ADDR_SEL_HI,
                   32'(c) << lsb((i - 4) % 6), 4'hf);
            @(posedge clk);
            stim[31:0] <= ok ? (32'h1 << c) : 32'hffff_ffff;
            nap();
            check("selected source", cpu_int[i], ok);
            @(posedge clk);
            stim[31:0] <= '0;
        end
        $display("source codes done");
        for (int ch = 0; ch < 64; ch++) begin
            k = ch_idx(ch);
            if (k >= 0) begin
                put(k, 1'b1);
            end else begin
                nap();
            end
            check("channel event", dma_evt, (k >= 0) ? (64'h1 << ch) : 64'h0);
            check("disabled request", dma_req, 64'h0);
            if (k >= 0) begin
                put(k, 1'b0);
            end
            @(posedge clk);
            xd <= 64'h1 << ch;
            nap();
            check("completion sync", dma_evt, 64'h1 << ch);
            @(posedge clk);
            xd <= '0;
            axd <= 64'h1 << ch;
            nap();
            check("alternate sync", dma_evt, 64'h1 << ch);
            @(posedge clk);
            axd <= '0;
        end
        $display("channel map done");
        wr_reg(IESEL_ADDR_CAP_LO, 32'hffff_ffff, 4'hf);
        wr_reg(IESEL_ADDR_CAP_HI, 32'hffff_ffff, 4'hf);
        rd_chk("capture cleared", IESEL_ADDR_CAP_LO, 32'h0);
        put(4, 1'b1);
        put(4, 1'b0);
        rd_chk("captured while disabled", IESEL_ADDR_CAP_LO, 32'h10);
        check("no request while disabled", dma_req, 64'h0);
        wr_reg(IESEL_ADDR_EN_LO, 32'h10, 4'hf);
        nap();
        check("request after enable", dma_req, 64'h10);
        wr_reg(IESEL_ADDR_CAP_LO, 32'h10, 4'hf);
        nap();
        check("request after clear", dma_req, 64'h0);
        wr_reg(IESEL_ADDR_EN_HI, 32'h1, 4'hf);
        rd_chk("high enable readback", IESEL_ADDR_EN_HI, 32'h1);
        put(53, 1'b1);
        put(53, 1'b0);
        check("cell channel request", dma_req, 64'h1 << 32);
        rd_chk("high capture", IESEL_ADDR_CAP_HI, 32'h1);
        $display("capture done");
        @(posedge clk);
        core_rst <= 1'b1;
        nmi <= 1'b1;
        nap();
        check("fixed inputs", cpu_int[3:0], 4'h3);
        check("top priority", top_int, 5'h00);
        @(posedge clk);
        core_rst <= 1'b0;
        nap();
        check("next priority", top_int, 5'h01);
        $display("fixed inputs done");
        // Mid-run reset must bring back the default routing
        @(posedge clk);
        srst <= 1'b1;
        nap();
        check("outputs in reset", {cpu_int, dma_req[47:0]}, 64'h0);
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk("low selector after reset", IESEL_ADDR_SEL_LO, pack(0));
        rd_chk("high selector after reset", IESEL_ADDR_SEL_HI, pack(6));
        rd_chk("high enable after reset", IESEL_ADDR_EN_HI, 32'h0);
        $display("mid-run reset done");
        results();
    end
endmodule
